// *** verilog/scti_defs.vh ***
// Register map, field positions and timing constants for the smart card control slice
// Assumes inclusion by bare name from each design file of the slice
`ifndef SCTI_DEFS_VH
`define SCTI_DEFS_VH

// Register byte offsets
`define SCTI_OFS_TIMER0 12'h028
`define SCTI_OFS_TIMER1 12'h02C
`define SCTI_OFS_TIMER2 12'h030
`define SCTI_OFS_FRAMING 12'h034
`define SCTI_OFS_ACTIVATE 12'h04C

// Timer control fields
`define SCTI_PEND_BIT 31
`define SCTI_MODE_HI 27
`define SCTI_MODE_LO 24
`define SCTI_T0_W 24
`define SCTI_T12_W 8

// Serial framing fields
`define SCTI_PAR_SENSE_BIT 7
`define SCTI_PAR_OFF_BIT 6
`define SCTI_WLEN_HI 5
`define SCTI_WLEN_LO 4
`define SCTI_PLAIN_BIT 0

// Activation extension field and its scale in card clock cycles
`define SCTI_EXT_HI 4
`define SCTI_EXT_SCALE 2048

// Timer modes
`define SCTI_MODE_STOP 4'h0
`define SCTI_MODE_ONCE 4'h1

// Reset values
`define SCTI_RST_WORD 32'h0000_0000

`endif

// *** verilog/scti_timer.v ***
// One ETU-based timer: shadowed write, pending flag, mode field and down counter
// Assumes card_tick and etu_tick are one-cycle enables on the same clock
`include "scti_defs.vh"

module scti_timer #(
	parameter CW = 8
) (
	input wire clk,
	input wire rst,
	input wire wr_en,
	input wire [3:0] wr_mode,
	input wire [CW-1:0] wr_count,
	input wire card_tick,
	input wire etu_tick,
	output reg [3:0] mode_reg,
	output reg [CW-1:0] count_reg,
	output reg pending_reg
);

	reg [3:0] shadow_mode_reg; // Value waiting to be taken in
	reg [CW-1:0] shadow_count_reg; // Reload and start value

	// Shadow capture, card-side take-over and counting
	always @(posedge clk) begin
		if (rst) begin
			shadow_mode_reg <= 4'h0;
			shadow_count_reg <= {CW{1'b0}};
			mode_reg <= 4'h0;
			count_reg <= {CW{1'b0}};
			pending_reg <= 1'b0;
		end else begin
			if (wr_en) begin
				// A new write keeps the flag up even on a take-over edge
				shadow_mode_reg <= wr_mode;
				shadow_count_reg <= wr_count;
				pending_reg <= 1'b1;
			end else if (pending_reg && card_tick) begin
				pending_reg <= 1'b0;
			end
			if (pending_reg && card_tick && !wr_en) begin
				// Card clock side takes the shadow value
				mode_reg <= shadow_mode_reg;
				count_reg <= shadow_count_reg;
			end else if (etu_tick && mode_reg != `SCTI_MODE_STOP) begin
				// Count in elementary time units
				if (count_reg != {CW{1'b0}}) begin
					count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
				end else if (mode_reg == `SCTI_MODE_ONCE) begin
					mode_reg <= `SCTI_MODE_STOP; // Single shot ends
				end else begin
					count_reg <= shadow_count_reg; // Other modes reload
				end
			end
		end
	end

endmodule // scti_timer

// *** verilog/scti_activation.v ***
// First activation interval timer, counted in card clock cycles and lengthened by software
// Assumes start is a one-cycle pulse and card_tick a one-cycle enable on the same clock
`include "scti_defs.vh"

module scti_activation #(
	parameter BASE_CYCLES = 400,
	parameter AW = 17
) (
	input wire clk,
	input wire rst,
	input wire start,
	input wire [4:0] ext,
	input wire card_tick,
	output reg busy_reg,
	output reg done_reg
);

	localparam [AW-1:0] BASE_W = BASE_CYCLES; // Standard interval
	localparam [AW-1:0] SCALE_W = `SCTI_EXT_SCALE; // Extension unit

	reg [AW-1:0] left_reg; // Card cycles still to run
	wire [AW-1:0] ext_cycles; // Extension in card cycles

	assign ext_cycles = {{(AW-5){1'b0}}, ext} * SCALE_W;

	// Interval counter; a zero extension leaves only the standard part
	always @(posedge clk) begin
		if (rst) begin
			left_reg <= {AW{1'b0}};
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (start) begin
				left_reg <= BASE_W + ext_cycles;
				busy_reg <= 1'b1;
			end else if (busy_reg && card_tick) begin
				if (left_reg <= {{(AW-1){1'b0}}, 1'b1}) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
				left_reg <= left_reg - {{(AW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // scti_activation

// *** verilog/scti_top.v ***
// Smart card control slice: APB registers, three ETU timers, framing control, activation extend
// Assumes a single 125 MHz clock, APB master on the same clock, activation start from a pin
//
// Function
// - Pending flag in bit 31 while syncing
// - Timer zero 24-bit ETU count value
// - Timer zero mode field bits 27:24
// - Timer one 8-bit count, 23:8 reserved
// - Timer two 8-bit count, 23:8 reserved
// - Timers one, two mode bits 27:24
// - Parity sense: 0 even, 1 odd
// - Parity disable bit removes parity bit
// - Word length 00..11 gives 8..5 bits
// - Mode bit: 0 smart card, 1 UART
// - UART enable resets buffers and state machine
// - Activation lengthened by extension times 2048
// - Zero extension keeps standard activation time
//
// The implementer's own choice: the APB register port.
`include "scti_defs.vh"

module scti_top #(
	parameter CARD_DIV = 4,
	parameter ETU_DIV = 372,
	parameter ACT_BASE_CYCLES = 400
) (
	// Clock and reset
	input wire CLOCK_IN,
	input wire SYS_RST_IN,
	// APB slave
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output reg [31:0] PRDATA_OUT,
	output reg PREADY_OUT,
	output reg PSLVERR_OUT,
	// Activation pin and status
	input wire ACT_START_IN,
	output reg ACT_BUSY_OUT,
	output reg ACT_DONE_OUT,
	// Framing to the character engine
	output reg PARITY_ON_OUT,
	output reg PARITY_ODD_OUT,
	output reg [3:0] DATA_BITS_OUT,
	output reg PLAIN_SERIAL_OUT,
	output reg ENGINE_RESET_OUT,
	// Timer state for the character engine
	output reg [3:0] TIMER0_MODE_OUT,
	output reg [3:0] TIMER1_MODE_OUT,
	output reg [3:0] TIMER2_MODE_OUT
);

	// Card clock and ETU enables
	reg [15:0] card_div_reg; // System cycles per card cycle
	reg [15:0] etu_div_reg; // Card cycles per ETU
	reg card_tick_reg;
	reg etu_tick_reg;

	// Software registers
	reg [7:0] framing_reg; // Parity, word length, mode
	reg [4:0] ext_reg; // Activation extension
	reg plain_prev_reg; // Mode bit last cycle

	// Pin synchroniser for activation start
	reg start_s1_reg;
	reg start_s2_reg;
	reg start_s3_reg;
	reg start_lvl_reg; // Agreed pin level

	// APB decode
	wire setup = PSEL_IN & ~PENABLE_IN;
	wire wr_now = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN & ~PSLVERR_OUT;
	wire hit_t0 = PADDR_IN == `SCTI_OFS_TIMER0;
	wire hit_t1 = PADDR_IN == `SCTI_OFS_TIMER1;
	wire hit_t2 = PADDR_IN == `SCTI_OFS_TIMER2;
	wire hit_fr = PADDR_IN == `SCTI_OFS_FRAMING;
	wire hit_ac = PADDR_IN == `SCTI_OFS_ACTIVATE;
	wire mapped = hit_t0 | hit_t1 | hit_t2 | hit_fr | hit_ac;

	// Engine reset pulse from mode bit rising, also restarts activation logic
	wire plain_rise = framing_reg[`SCTI_PLAIN_BIT] & ~plain_prev_reg;
	wire start_edge = start_s2_reg & start_s3_reg & ~start_lvl_reg;
	wire sub_rst = SYS_RST_IN | plain_rise;

	// Timer state
	wire [3:0] t0_mode;
	wire [3:0] t1_mode;
	wire [3:0] t2_mode;
	wire [23:0] t0_count;
	wire [7:0] t1_count;
	wire [7:0] t2_count;
	wire t0_pend;
	wire t1_pend;
	wire t2_pend;
	wire act_busy;
	wire act_done;

	reg [31:0] rd_word; // Read mux

	// Divider end points, cut to the counter width on purpose
	localparam [15:0] CARD_LAST = CARD_DIV - 1; // Last system cycle of a card cycle
	localparam [15:0] ETU_LAST = ETU_DIV - 1; // Last card cycle of an ETU

	// Dividers for card clock and ETU enables
	// A card tick comes once every CARD_DIV system cycles
	// An ETU tick comes on every ETU_DIV-th card tick, in the same cycle as it
	// Both are one-cycle enables, so all logic stays on the one system clock
	always @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			card_div_reg <= 16'h0000;
			etu_div_reg <= 16'h0000;
			card_tick_reg <= 1'b0;
			etu_tick_reg <= 1'b0;
		end else begin
			card_tick_reg <= 1'b0;
			etu_tick_reg <= 1'b0;
			if (card_div_reg == CARD_LAST) begin
				card_div_reg <= 16'h0000;
				card_tick_reg <= 1'b1;
				if (etu_div_reg == ETU_LAST) begin
					etu_div_reg <= 16'h0000;
					etu_tick_reg <= 1'b1;
				end else begin
					etu_div_reg <= etu_div_reg + 16'h0001;
				end
			end else begin
				card_div_reg <= card_div_reg + 16'h0001;
			end
		end
	end

	// Three-stage pin synchroniser; a change counts once stages two and three agree
	// Stage one may go metastable, so only stage two reads it
	// The agreed level starts low, the idle pin level, so reset gives no false edge
	always @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			start_s1_reg <= 1'b0;
			start_s2_reg <= 1'b0;
			start_s3_reg <= 1'b0;
			start_lvl_reg <= 1'b0;
		end else begin
			start_s1_reg <= ACT_START_IN;
			start_s2_reg <= start_s1_reg;
			start_s3_reg <= start_s2_reg;
			if (start_s2_reg == start_s3_reg) begin
				start_lvl_reg <= start_s3_reg;
			end
		end
	end

	// Software-written framing and extension registers
	// Writes land at the access edge with ready high and no error
	// The mode bit is kept one cycle back to find its rising edge
	always @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			framing_reg <= 8'h00;
			ext_reg <= 5'h00;
			plain_prev_reg <= 1'b0;
		end else begin
			plain_prev_reg <= framing_reg[`SCTI_PLAIN_BIT];
			if (wr_now && hit_fr) begin
				// Reserved bits 3:1 are not stored
				framing_reg <= PWDATA_IN[7:0] & 8'hF1;
			end
			if (wr_now && hit_ac) begin
				ext_reg <= PWDATA_IN[`SCTI_EXT_HI:0];
			end
		end
	end

	// Read data assembly; reserved bits read as zero
	// Bit 31 of each timer word is the pending flag, read only
	// Writes to it and to reserved bits are dropped
	always @* begin
		rd_word = `SCTI_RST_WORD;
		if (hit_t0) begin
			rd_word = {t0_pend, 3'b000, t0_mode, t0_count};
		end else if (hit_t1) begin
			rd_word = {t1_pend, 3'b000, t1_mode, 16'h0000, t1_count};
		end else if (hit_t2) begin
			rd_word = {t2_pend, 3'b000, t2_mode, 16'h0000, t2_count};
		end else if (hit_fr) begin
			rd_word = {24'h00_0000, framing_reg};
		end else if (hit_ac) begin
			rd_word = {27'h000_0000, ext_reg};
		end
	end

	// APB answer: ready in the first access cycle, error for unmapped addresses
	// Ready follows every setup cycle by one clock, so there are no wait states
	// Read data is taken at the setup edge and stands until the next read setup
	// An unmapped address answers with an error and the write is dropped
	// Back-to-back transfers work, since the access cycle never looks like a setup
	always @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			PRDATA_OUT <= `SCTI_RST_WORD;
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= setup;
			PSLVERR_OUT <= setup & ~mapped;
			if (setup && !PWRITE_IN) begin
				PRDATA_OUT <= rd_word;
			end
		end
	end

	// Each timer keeps a shadow of the written word and takes it in at the next card tick
	// The pending flag stands from the write until that take-over
	// Software polls it low before it writes the same timer again
	// A write on a take-over edge keeps the flag up, so the newer value is taken next
	// Timer zero, 24 bits
	scti_timer #(.CW(`SCTI_T0_W)) u_timer0 (
		.clk(CLOCK_IN),
		.rst(SYS_RST_IN),
		.wr_en(wr_now & hit_t0),
		.wr_mode(PWDATA_IN[`SCTI_MODE_HI:`SCTI_MODE_LO]),
		.wr_count(PWDATA_IN[23:0]),
		.card_tick(card_tick_reg),
		.etu_tick(etu_tick_reg),
		.mode_reg(t0_mode),
		.count_reg(t0_count),
		.pending_reg(t0_pend)
	);

	// Timer one, 8 bits
	scti_timer #(.CW(`SCTI_T12_W)) u_timer1 (
		.clk(CLOCK_IN),
		.rst(SYS_RST_IN),
		.wr_en(wr_now & hit_t1),
		.wr_mode(PWDATA_IN[`SCTI_MODE_HI:`SCTI_MODE_LO]),
		.wr_count(PWDATA_IN[7:0]),
		.card_tick(card_tick_reg),
		.etu_tick(etu_tick_reg),
		.mode_reg(t1_mode),
		.count_reg(t1_count),
		.pending_reg(t1_pend)
	);

	// Timer two, 8 bits
	scti_timer #(.CW(`SCTI_T12_W)) u_timer2 (
		.clk(CLOCK_IN),
		.rst(SYS_RST_IN),
		.wr_en(wr_now & hit_t2),
		.wr_mode(PWDATA_IN[`SCTI_MODE_HI:`SCTI_MODE_LO]),
		.wr_count(PWDATA_IN[7:0]),
		.card_tick(card_tick_reg),
		.etu_tick(etu_tick_reg),
		.mode_reg(t2_mode),
		.count_reg(t2_count),
		.pending_reg(t2_pend)
	);

	// Activation first interval
	// A rising edge on the synchronised pin starts the interval
	// Entering plain serial mode restarts this logic along with the character engine
	// The interval is counted in card ticks as one down count of the base part plus the extension
	scti_activation #(.BASE_CYCLES(ACT_BASE_CYCLES)) u_act (
		.clk(CLOCK_IN),
		.rst(sub_rst),
		.start(start_edge),
		.ext(ext_reg),
		.card_tick(card_tick_reg),
		.busy_reg(act_busy),
		.done_reg(act_done)
	);

	// Registered outputs toward the character engine and pins
	// Every output is one register behind the state it shows
	// Reset leaves smart card framing: parity on, even, eight data bits
	always @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			PARITY_ON_OUT <= 1'b1;
			PARITY_ODD_OUT <= 1'b0;
			DATA_BITS_OUT <= 4'h8;
			PLAIN_SERIAL_OUT <= 1'b0;
			ENGINE_RESET_OUT <= 1'b0;
			ACT_BUSY_OUT <= 1'b0;
			ACT_DONE_OUT <= 1'b0;
			TIMER0_MODE_OUT <= 4'h0;
			TIMER1_MODE_OUT <= 4'h0;
			TIMER2_MODE_OUT <= 4'h0;
		end else begin
			PARITY_ON_OUT <= ~framing_reg[`SCTI_PAR_OFF_BIT];
			// Sense only matters while parity is on
			PARITY_ODD_OUT <= framing_reg[`SCTI_PAR_SENSE_BIT] & ~framing_reg[`SCTI_PAR_OFF_BIT];
			DATA_BITS_OUT <= 4'h8 - {2'b00, framing_reg[`SCTI_WLEN_HI:`SCTI_WLEN_LO]};
			PLAIN_SERIAL_OUT <= framing_reg[`SCTI_PLAIN_BIT];
			ENGINE_RESET_OUT <= plain_rise;
			ACT_BUSY_OUT <= act_busy;
			ACT_DONE_OUT <= act_done;
			TIMER0_MODE_OUT <= t0_mode;
			TIMER1_MODE_OUT <= t1_mode;
			TIMER2_MODE_OUT <= t2_mode;
		end
	end

endmodule // scti_top

// *** bench/scti_chk_sva.sv ***
// Port checker for the smart card control slice: APB answer, framing outputs, activation status
// Assumes one clock domain with a synchronous active-high reset
module scti_chk #(
	parameter CARD_DIV = 4,
	parameter ETU_DIV = 372,
	parameter ACT_BASE_CYCLES = 400
) (
	// Clock, reset and APB
	input wire CLOCK_IN, SYS_RST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire PREADY_OUT, PSLVERR_OUT,
	// Activation and framing
	input wire ACT_BUSY_OUT, ACT_DONE_OUT, PARITY_ON_OUT, PARITY_ODD_OUT,
	input wire PLAIN_SERIAL_OUT, ENGINE_RESET_OUT,
	input wire [3:0] DATA_BITS_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// Completed write to the framing register
	sequence s_wr_fr;
		PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h034;
	endsequence
	// Setup phase of any transfer
	sequence s_setup;
		PSEL_IN && !PENABLE_IN;
	endsequence
	a_ready_once: assert property (s_setup |=> PREADY_OUT ##1 !PREADY_OUT)
		else $error("ready not a single cycle after setup");
	a_err_unmapped: assert property (PSLVERR_OUT |-> PREADY_OUT &&
		!(PADDR_IN inside {12'h028, 12'h02C, 12'h030, 12'h034, 12'h04C}))
		else $error("error answer on a mapped address");
	a_parity_off: assert property (s_wr_fr ##0 PWDATA_IN[6] |-> ##2 !PARITY_ON_OUT && !PARITY_ODD_OUT)
		else $error("parity still on after disable");
	a_parity_on: assert property (s_wr_fr ##0 !PWDATA_IN[6] |-> ##2 PARITY_ON_OUT)
		else $error("parity off after enable");
	a_odd_sense: assert property (s_wr_fr ##0 PWDATA_IN[7:6] == 2'b10 |-> ##2 PARITY_ODD_OUT)
		else $error("odd parity not selected");
	a_word_len: assert property (s_wr_fr ##0 PWDATA_IN[5:4] == 2'b11 |-> ##2 DATA_BITS_OUT == 4'd5)
		else $error("word length not five");
	a_plain_mode: assert property (s_wr_fr ##0 PWDATA_IN[0] |-> ##2 PLAIN_SERIAL_OUT)
		else $error("plain serial mode not taken");
	a_engine_pulse: assert property (ENGINE_RESET_OUT |-> PLAIN_SERIAL_OUT ##1 !ENGINE_RESET_OUT)
		else $error("engine reset not a pulse on mode entry");
	a_done_after: assert property (ACT_DONE_OUT |-> $past(ACT_BUSY_OUT, 2) ##1 !ACT_DONE_OUT)
		else $error("done without a running interval");
	a_busy_min: assert property ($rose(ACT_BUSY_OUT) |-> ACT_BUSY_OUT[*8])
		else $error("activation interval too short");
endmodule // scti_chk
bind scti_top scti_chk #(.CARD_DIV(CARD_DIV), .ETU_DIV(ETU_DIV), .ACT_BASE_CYCLES(ACT_BASE_CYCLES)) u_chk (
	.CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .ACT_BUSY_OUT(ACT_BUSY_OUT), .ACT_DONE_OUT(ACT_DONE_OUT),
	.PARITY_ON_OUT(PARITY_ON_OUT), .PARITY_ODD_OUT(PARITY_ODD_OUT), .PLAIN_SERIAL_OUT(PLAIN_SERIAL_OUT),
	.ENGINE_RESET_OUT(ENGINE_RESET_OUT), .DATA_BITS_OUT(DATA_BITS_OUT));

// *** bench/scti_card.sv ***
// Card side model: raises the activation pin when the bench asks for a card session
// Assumes the pin is asynchronous to the slice and idles low between sessions
module scti_card (
	input wire logic clk,
	input wire logic go,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pin low until a session is requested
	initial pin = 1'b0;
	// Pin follows the request one clock later
	always @(posedge clk) begin
		pin <= go;
	end
endmodule // scti_card

// *** bench/tb.sv ***
// Self-checking bench: register rows, timer modes, activation lengths, mid-run reset
// Assumes small divider values so activation with extension fits the run
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e; logic [6:0] o;} row_t;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwd = 0, rd;
	wire [31:0] prd;
	wire prdy, perr, busy, done, pon, podd, plain, erst, pin;
	wire [3:0] bits, m0, m1, m2;
	int bad_count = 0, checks_done = 0, cyc = 0, pulses = 0, k, n, x;
	logic [11:0] regs[5] = '{12'h028, 12'h02C, 12'h030, 12'h034, 12'h04C};
	row_t rows[10] = '{
		'{12'h028, 32'h70AB_CDEF, 32'h00AB_CDEF, 1'b0, 7'b1010000},
		'{12'h02C, 32'hF0FF_FF5A, 32'h0000_005A, 1'b0, 7'b1010000},
		'{12'h030, 32'h70FF_FFA5, 32'h0000_00A5, 1'b0, 7'b1010000},
		'{12'h04C, 32'hFFFF_FFE0, 32'h0000_0000, 1'b0, 7'b1010000},
		'{12'h040, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 7'b1010000},
		'{12'h034, 32'h0000_0080, 32'h0000_0080, 1'b0, 7'b1110000},
		'{12'h034, 32'h0000_00D0, 32'h0000_00D0, 1'b0, 7'b0001110},
		'{12'h034, 32'h0000_0020, 32'h0000_0020, 1'b0, 7'b1001100},
		'{12'h034, 32'hFFFF_FF3E, 32'h0000_0030, 1'b0, 7'b1001010},
		'{12'h034, 32'h0000_0001, 32'h0000_0001, 1'b0, 7'b1010001}};
	scti_top #(.CARD_DIV(16), .ETU_DIV(2), .ACT_BASE_CYCLES(10)) dut (
		.CLOCK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
		.ACT_START_IN(pin), .ACT_BUSY_OUT(busy), .ACT_DONE_OUT(done), .PARITY_ON_OUT(pon),
		.PARITY_ODD_OUT(podd), .DATA_BITS_OUT(bits), .PLAIN_SERIAL_OUT(plain), .ENGINE_RESET_OUT(erst),
		.TIMER0_MODE_OUT(m0), .TIMER1_MODE_OUT(m1), .TIMER2_MODE_OUT(m2));
	scti_card u_card (.clk(clk), .go(go), .pin(pin));
	// Free-running clock
	initial begin
		forever #4 clk = ~clk;
	end
	// Closing report
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One comparison
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until ready is sampled
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		// Wait for ready; only the bench cycle limit ends a hang
		do @(posedge clk); while (prdy !== 1);
		rd = prd;
		er = perr;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	// Read until the pending flag clears
	task rdp(input logic [11:0] a);
		k = 0;
		do apb(0, a, 0); while (rd[31] !== 0 && ++k < 30);
	endtask
	// One activation with the given extension, length checked in clocks
	task act(input int ext);
		apb(1, 12'h04C, ext);
		go <= 1;
		k = 0;
		while (busy !== 1 && k < 50) begin @(posedge clk); k++; end
		n = 0;
		while (done !== 1 && n < 40000) begin @(posedge clk); n++; end
		go <= 0;
		x = (10 + ext * 2048) * 16;
		chk(n >= x - 32 && n <= x + 32, 1);
	endtask
	// Cycle limit and engine reset pulse count
	always @(posedge clk) begin
		cyc++;
		if (erst === 1) pulses++;
		if (cyc == 60000) begin bad_count++; summarize; end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		for (int i = 0; i < 10; i++) begin
			apb(1, rows[i].a, rows[i].d);
			rdp(rows[i].a);
			chk(rd, rows[i].r);
			chk(er, rows[i].e);
			chk({pon, podd, bits, plain}, rows[i].o);
		end
		chk(pulses, 1);
		$display("test rows done");
		for (int m = 0; m < 16; m++) begin
			apb(1, 12'h02C, (m << 24) | 32'h0000_00FF);
			rdp(12'h02C);
			chk(m1, m);
			chk(rd[27:24], m);
		end
		apb(1, 12'h030, 32'h0100_0002);
		rdp(12'h030);
		chk(m2, 1);
		apb(1, 12'h028, 32'h0200_0003);
		k = 0;
		while (m2 !== 0 && k < 200) begin @(posedge clk); k++; end
		chk(m2, 0);
		apb(0, 12'h030, 0);
		chk(rd, 0);
		chk(m0, 2);
		$display("test modes done");
		act(0);
		act(1);
		$display("test activation done");
		rst <= 1;
		repeat (4) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		for (int i = 0; i < 5; i++) begin
			apb(0, regs[i], 0);
			chk(rd, 0);
		end
		chk({pon, podd, bits, plain}, 7'b1010000);
		$display("test reset done");
		summarize;
	end
endmodule // tb
